// file: rtl/irc_consts.svh
/*
 holds: register indices, field positions, reset values and decode constants of the
 isa resource configuration block.
 assumes: included by its bare name after the package; register byte address is four times the index.
*/
// How it works
// - io window claimed when system address bits 8..5 equal io base code; bases 200..3e0.
// - after reset, io, dma and boot base codes load from configuration memory contents.
// - interrupt code picks isa line 3,4,5,9,10,11,12 or 15; line 3 default.
// - no interrupt request line is driven until the activate bit is set.
// - interrupt type bit: 1 selects level, 0 selects edge; edge is the default.
// - interrupt polarity bit is read-only and always reads as inverse of type.
// - dma code picks channel 3,5,6 or 7; code 100 selects no channel.
// - in bus-master mode no dma request is driven until activate is set.
// - boot base code matches address bits 16..13, placing boot memory c0000..de000.
// - memory windows are size aligned; a base that cannot hold the size selects nothing.
// - boot cycles answer 16-bit when wide bit set, but always 8-bit in bus-master mode.
// - boot size code: top bit 0 none, 1111 8k, 1110 16k, 1100 32k, 1000 64k.
// - shared base low bits match address 15..13; upper bits mirror external 17..16 decode.
// - shared base takes effect only in shared-memory mode.
// - shared cycles answer 16-bit when wide bit set, except bus-master or programmed-io modes.
// - shared size code decodes like boot size and is ignored outside shared-memory mode.
// - bit 0 of register 30 is activate, enabling configured resources onto the bus.
`ifndef IRC_CONSTS_SVH
`define IRC_CONSTS_SVH

`define IRC_IDX_ACTIVATE 8'h30
`define IRC_IDX_BOOT_BASE_HI 8'h40
`define IRC_IDX_BOOT_BASE_LO 8'h41
`define IRC_IDX_BOOT_WIDTH 8'h42
`define IRC_IDX_BOOT_SIZE_HI 8'h43
`define IRC_IDX_BOOT_SIZE_LO 8'h44
`define IRC_IDX_SHM_BASE_HI 8'h48
`define IRC_IDX_SHM_BASE_LO 8'h49
`define IRC_IDX_SHM_WIDTH 8'h4a
`define IRC_IDX_SHM_SIZE_HI 8'h4b
`define IRC_IDX_SHM_SIZE_LO 8'h4c
`define IRC_IDX_ARCH_MODE 8'h50
`define IRC_IDX_IO_BASE_HI 8'h60
`define IRC_IDX_IO_BASE_LO 8'h61
`define IRC_IDX_IRQ_SEL 8'h70
`define IRC_IDX_IRQ_TYPE 8'h71
`define IRC_IDX_DMA_SEL 8'h74

`define IRC_HI_CODE_POS 0
`define IRC_LO_CODE_POS 5
`define IRC_WIDE_POS 1
`define IRC_ACT_POS 0
`define IRC_TYPE_POS 0
`define IRC_POL_POS 1

`define IRC_IO_HI_FIXED 8'h02
`define IRC_MEM_HI_FIXED 8'h0c
`define IRC_SIZE_HI_FIXED 8'hfe

`define IRC_RST_IO_CODE 4'h0
`define IRC_RST_IRQ_CODE 4'h3
`define IRC_RST_DMA_CODE 3'h4
`define IRC_RST_BOOT_CODE 4'h0
`define IRC_RST_SIZE_CODE 4'h0
`define IRC_RST_SHM_CODE 5'h00

`define IRC_BOOT_REGION 3'h6
`define IRC_SIZE_8K 4'hf
`define IRC_SIZE_16K 4'he
`define IRC_SIZE_32K 4'hc
`define IRC_SIZE_64K 4'h8

`endif

// file: rtl/irc_pkg.sv
/*
 holds: types of the isa resource configuration block.
 assumes: nothing beyond a systemverilog compiler.
*/
package irc_pkg;
  typedef enum logic [2:0] {
    IRC_BUS_MASTER = 3'b001,
    IRC_SHARED_MEM = 3'b010,
    IRC_PROG_IO = 3'b100
  } irc_mode_t;
endpackage : irc_pkg

// file: rtl/irc_top.sv
/*
 holds: resource configuration registers on apb, isa address decode, interrupt and dma line steering.
 assumes: isa address and request inputs are synchronous to pclk; the configuration memory reader
 pulses load_valid once after reset; outside logic resolves line levels from the enables.
*/
`timescale 1ns/1ps
`include "irc_consts.svh"

module irc_top
  import irc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [9:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic load_valid,
  input wire logic [3:0] load_io_code,
  input wire logic [2:0] load_dma_code,
  input wire logic [3:0] load_boot_code,
  input wire logic [19:0] sa,
  input wire logic ext_shared_match,
  input wire logic int_req,
  input wire logic dma_req,
  output logic io_select,
  output logic boot_select,
  output logic boot_wide,
  output logic shared_select,
  output logic shared_wide,
  output logic [15:0] irq_out,
  output logic [15:0] irq_oe,
  output logic [7:0] drq_out,
  output logic [7:0] drq_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers

  function automatic logic [15:0] irc_irq_line(input logic [3:0] code);
    logic [15:0] line;
    line = 16'h0000;
    case (code)
      4'h3: line = 16'h0008;
      4'h4: line = 16'h0010;
      4'h5: line = 16'h0020;
      4'h9: line = 16'h0200;
      4'ha: line = 16'h0400;
      4'hb: line = 16'h0800;
      4'hd: line = 16'h1000;
      4'he: line = 16'h8000;
      default: line = 16'h0000;
    endcase
    return line;
  endfunction : irc_irq_line

  function automatic logic [7:0] irc_dma_line(input logic [2:0] code);
    logic [7:0] line;
    line = 8'h00;
    case (code)
      3'h3: line = 8'h08;
      3'h5: line = 8'h20;
      3'h6: line = 8'h40;
      3'h7: line = 8'h80;
      default: line = 8'h00;
    endcase
    return line;
  endfunction : irc_dma_line

  // address bits left out of the compare for a size; 4'hf flags an invalid size code
  function automatic logic [3:0] irc_ignore(input logic [3:0] size);
    logic [3:0] ign;
    ign = 4'hf;
    case (size)
      `IRC_SIZE_8K: ign = 4'h0;
      `IRC_SIZE_16K: ign = 4'h1;
      `IRC_SIZE_32K: ign = 4'h3;
      `IRC_SIZE_64K: ign = 4'h7;
      default: ign = 4'hf;
    endcase
    return ign;
  endfunction : irc_ignore

  ////////////////////////////////////////////////////////////////////////////
  // configuration state

  logic activate;
  logic [3:0] io_code;
  logic [3:0] irq_code;
  logic irq_level;
  logic [2:0] dma_code;
  logic [3:0] boot_code;
  logic boot_wide_access;
  logic [3:0] boot_size_code;
  logic [4:0] shm_code;
  logic shared_mem_wide_access;
  logic [3:0] shared_mem_size_code;
  irc_mode_t mode;

  logic [7:0] idx;
  logic idx_ok;
  logic [7:0] rd_val;
  logic hit;
  logic wr_en;
  logic [7:0] wd;

  assign idx = paddr[9:2];
  assign idx_ok = (paddr[1:0] == 2'h0);
  assign wd = pwdata[7:0];
  assign wr_en = psel & penable & pready & pwrite & hit;

  ////////////////////////////////////////////////////////////////////////////
  // register read decode

  always_comb begin
    rd_val = 8'h00;
    hit = idx_ok;
    if (!idx_ok) begin
      hit = 1'b0;
    end else if (idx == `IRC_IDX_ACTIVATE) begin
      rd_val = {7'h00, activate};
    end else if (idx == `IRC_IDX_IO_BASE_HI) begin
      rd_val = `IRC_IO_HI_FIXED | {7'h00, io_code[3]};
    end else if (idx == `IRC_IDX_IO_BASE_LO) begin
      rd_val = {io_code[2:0], 5'h00};
    end else if (idx == `IRC_IDX_IRQ_SEL) begin
      rd_val = {4'h0, irq_code};
    end else if (idx == `IRC_IDX_IRQ_TYPE) begin
      rd_val = {6'h00, ~irq_level, irq_level};
    end else if (idx == `IRC_IDX_DMA_SEL) begin
      rd_val = {5'h00, dma_code};
    end else if (idx == `IRC_IDX_BOOT_BASE_HI) begin
      rd_val = `IRC_MEM_HI_FIXED | {7'h00, boot_code[3]};
    end else if (idx == `IRC_IDX_BOOT_BASE_LO) begin
      rd_val = {boot_code[2:0], 5'h00};
    end else if (idx == `IRC_IDX_BOOT_WIDTH) begin
      rd_val = {6'h00, boot_wide_access, 1'b0};
    end else if (idx == `IRC_IDX_BOOT_SIZE_HI) begin
      rd_val = `IRC_SIZE_HI_FIXED | {7'h00, boot_size_code[3]};
    end else if (idx == `IRC_IDX_BOOT_SIZE_LO) begin
      rd_val = {boot_size_code[2:0], 5'h00};
    end else if (idx == `IRC_IDX_SHM_BASE_HI) begin
      rd_val = `IRC_MEM_HI_FIXED | {6'h00, shm_code[4:3]};
    end else if (idx == `IRC_IDX_SHM_BASE_LO) begin
      rd_val = {shm_code[2:0], 5'h00};
    end else if (idx == `IRC_IDX_SHM_WIDTH) begin
      rd_val = {6'h00, shared_mem_wide_access, 1'b0};
    end else if (idx == `IRC_IDX_SHM_SIZE_HI) begin
      rd_val = `IRC_SIZE_HI_FIXED | {7'h00, shared_mem_size_code[3]};
    end else if (idx == `IRC_IDX_SHM_SIZE_LO) begin
      rd_val = {shared_mem_size_code[2:0], 5'h00};
    end else if (idx == `IRC_IDX_ARCH_MODE) begin
      rd_val = {5'h00, mode};
    end else begin
      hit = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb answer: one access cycle, answered from flops loaded in the setup cycle

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~hit;
      prdata <= (psel & ~penable & ~pwrite) ? {24'h00_0000, rd_val} : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // codes that the configuration memory also loads; the load wins over a write in the same cycle

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      io_code <= `IRC_RST_IO_CODE;
      dma_code <= `IRC_RST_DMA_CODE;
      boot_code <= `IRC_RST_BOOT_CODE;
    end else if (load_valid) begin
      io_code <= load_io_code;
      dma_code <= load_dma_code;
      boot_code <= load_boot_code;
    end else if (wr_en) begin
      if (idx == `IRC_IDX_IO_BASE_HI) begin
        io_code[3] <= wd[`IRC_HI_CODE_POS];
      end else if (idx == `IRC_IDX_IO_BASE_LO) begin
        io_code[2:0] <= wd[`IRC_LO_CODE_POS +: 3];
      end else if (idx == `IRC_IDX_DMA_SEL) begin
        dma_code <= wd[2:0];
      end else if (idx == `IRC_IDX_BOOT_BASE_HI) begin
        boot_code[3] <= wd[`IRC_HI_CODE_POS];
      end else if (idx == `IRC_IDX_BOOT_BASE_LO) begin
        boot_code[2:0] <= wd[`IRC_LO_CODE_POS +: 3];
      end
    end
  end

  // software-only fields
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      activate <= 1'b0;
      irq_code <= `IRC_RST_IRQ_CODE;
      irq_level <= 1'b0;
      boot_wide_access <= 1'b0;
      boot_size_code <= `IRC_RST_SIZE_CODE;
      shm_code <= `IRC_RST_SHM_CODE;
      shared_mem_wide_access <= 1'b0;
      shared_mem_size_code <= `IRC_RST_SIZE_CODE;
    end else if (wr_en) begin
      if (idx == `IRC_IDX_ACTIVATE) begin
        activate <= wd[`IRC_ACT_POS];
      end else if (idx == `IRC_IDX_IRQ_SEL) begin
        irq_code <= wd[3:0];
      end else if (idx == `IRC_IDX_IRQ_TYPE) begin
        irq_level <= wd[`IRC_TYPE_POS];
      end else if (idx == `IRC_IDX_BOOT_WIDTH) begin
        boot_wide_access <= wd[`IRC_WIDE_POS];
      end else if (idx == `IRC_IDX_BOOT_SIZE_HI) begin
        boot_size_code[3] <= wd[`IRC_HI_CODE_POS];
      end else if (idx == `IRC_IDX_BOOT_SIZE_LO) begin
        boot_size_code[2:0] <= wd[`IRC_LO_CODE_POS +: 3];
      end else if (idx == `IRC_IDX_SHM_BASE_HI) begin
        shm_code[4:3] <= wd[`IRC_HI_CODE_POS +: 2];
      end else if (idx == `IRC_IDX_SHM_BASE_LO) begin
        shm_code[2:0] <= wd[`IRC_LO_CODE_POS +: 3];
      end else if (idx == `IRC_IDX_SHM_WIDTH) begin
        shared_mem_wide_access <= wd[`IRC_WIDE_POS];
      end else if (idx == `IRC_IDX_SHM_SIZE_HI) begin
        shared_mem_size_code[3] <= wd[`IRC_HI_CODE_POS];
      end else if (idx == `IRC_IDX_SHM_SIZE_LO) begin
        shared_mem_size_code[2:0] <= wd[`IRC_LO_CODE_POS +: 3];
      end
    end
  end

  // unknown mode values keep the previous mode so the decode never sees a non one-hot code
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode <= IRC_BUS_MASTER;
    end else if (wr_en && idx == `IRC_IDX_ARCH_MODE) begin
      case (wd[2:0])
        3'h1: mode <= IRC_BUS_MASTER;
        3'h2: mode <= IRC_SHARED_MEM;
        3'h4: mode <= IRC_PROG_IO;
        default: mode <= mode;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // isa decode

  logic [3:0] boot_ign;
  logic [3:0] shm_ign;
  logic boot_fit;
  logic shm_fit;
  logic next_io_select;
  logic next_boot_select;
  logic next_shared_select;
  logic [15:0] irq_lines;
  logic [7:0] dma_lines;
  logic irq_level_out;

  assign boot_ign = irc_ignore(boot_size_code);
  assign shm_ign = irc_ignore(shared_mem_size_code);
  // a base off its size boundary would alias; refusing it is cheaper than guessing
  assign boot_fit = boot_size_code[3] && (boot_ign != 4'hf) && ((boot_code & boot_ign) == 4'h0);
  assign shm_fit = shared_mem_size_code[3] && (shm_ign != 4'hf)
    && ((shm_code[2:0] & shm_ign[2:0]) == 3'h0);
  assign next_io_select = activate && sa[9] && (sa[8:5] == io_code);
  assign next_boot_select = activate && boot_fit && (sa[19:17] == `IRC_BOOT_REGION)
    && (((sa[16:13] ^ boot_code) & ~boot_ign) == 4'h0);
  assign next_shared_select = activate && (mode == IRC_SHARED_MEM) && shm_fit && ext_shared_match
    && (((sa[15:13] ^ shm_code[2:0]) & ~shm_ign[2:0]) == 3'h0);
  assign irq_lines = irc_irq_line(irq_code);
  assign dma_lines = irc_dma_line(dma_code);
  // level mode signals active low, edge mode active high
  assign irq_level_out = irq_level ? ~int_req : int_req;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      io_select <= 1'b0;
      boot_select <= 1'b0;
      shared_select <= 1'b0;
      boot_wide <= 1'b0;
      shared_wide <= 1'b0;
    end else begin
      io_select <= next_io_select;
      boot_select <= next_boot_select;
      shared_select <= next_shared_select;
      boot_wide <= next_boot_select && boot_wide_access && (mode != IRC_BUS_MASTER);
      shared_wide <= next_shared_select && shared_mem_wide_access;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_oe <= 16'h0000;
      irq_out <= 16'h0000;
    end else begin
      irq_oe <= activate ? irq_lines : 16'h0000;
      irq_out <= irq_lines & {16{irq_level_out}};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drq_oe <= 8'h00;
      drq_out <= 8'h00;
    end else begin
      drq_oe <= (activate && mode == IRC_BUS_MASTER) ? dma_lines : 8'h00;
      drq_out <= dma_lines & {8{dma_req}};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  chk_io_claim: assert property (@(posedge pclk) disable iff (!presetn)
    (activate && sa[9] && sa[8:5] == io_code) |=> io_select)
    else $error("io window not claimed");
  chk_load_codes: assert property (@(posedge pclk) disable iff (!presetn)
    load_valid |=> (io_code == $past(load_io_code) && dma_code == $past(load_dma_code)
      && boot_code == $past(load_boot_code)))
    else $error("configuration load lost");
  chk_irq_line3: assert property (@(posedge pclk) disable iff (!presetn)
    (activate && irq_code == 4'h3) |=> irq_oe == 16'h0008)
    else $error("interrupt line 3 not selected");
  chk_irq_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    !activate |=> irq_oe == 16'h0000)
    else $error("interrupt driven while inactive");
  chk_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    (irq_level && irq_code == 4'h9 && int_req) |=> irq_out == 16'h0000)
    else $error("level interrupt not active low");
  chk_pol_read: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && paddr == {`IRC_IDX_IRQ_TYPE, 2'h0}) |=> prdata[1] == ~prdata[0])
    else $error("polarity not inverse of type");
  chk_dma_ch5: assert property (@(posedge pclk) disable iff (!presetn)
    (activate && mode == IRC_BUS_MASTER && dma_code == 3'h5) |=> drq_oe == 8'h20)
    else $error("dma channel 5 not selected");
  chk_dma_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    (!activate || mode != IRC_BUS_MASTER) |=> drq_oe == 8'h00)
    else $error("dma request driven while inactive");
  chk_boot_region: assert property (@(posedge pclk) disable iff (!presetn)
    boot_select |-> $past(sa[19:17]) == 3'h6)
    else $error("boot selected outside region");
  chk_boot_align: assert property (@(posedge pclk) disable iff (!presetn)
    (boot_size_code == `IRC_SIZE_64K && boot_code[0]) |=> !boot_select)
    else $error("misaligned boot window selected");
  chk_boot_narrow: assert property (@(posedge pclk) disable iff (!presetn)
    (mode == IRC_BUS_MASTER) |=> !boot_wide)
    else $error("wide boot cycle in bus-master mode");
  chk_boot_none: assert property (@(posedge pclk) disable iff (!presetn)
    !boot_size_code[3] |=> !boot_select)
    else $error("boot selected with no size");
  chk_shm_mode: assert property (@(posedge pclk) disable iff (!presetn)
    (mode != IRC_SHARED_MEM) |=> (!shared_select && !shared_wide))
    else $error("shared memory selected outside its mode");
  chk_shm_ext: assert property (@(posedge pclk) disable iff (!presetn)
    !ext_shared_match |=> !shared_select)
    else $error("shared select without external match");
  chk_irq_bad: assert property (@(posedge pclk) disable iff (!presetn)
    (irq_code == 4'h7) |=> irq_oe == 16'h0000)
    else $error("unlisted interrupt code drives a line");
  chk_apb_once: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable) |=> pready ##1 !pready)
    else $error("apb answer not one cycle");

  cov_boot_hit: cover property (@(posedge pclk) disable iff (!presetn) boot_select && boot_wide);
  cov_shm_hit: cover property (@(posedge pclk) disable iff (!presetn) shared_select && shared_wide);
  cov_irq_on: cover property (@(posedge pclk) disable iff (!presetn) $rose(activate) ##1 irq_oe != 16'h0000);
  cov_dma_req: cover property (@(posedge pclk) disable iff (!presetn) drq_oe != 8'h00 && drq_out != 8'h00);

endmodule : irc_top

// file: test/irc_isa_host.sv
/*
 holds: isa host model: resolves request lines, mirrors the outside decode of the upper shared address bits.
 assumes: request outputs and enables come from the block; one clock.
*/
`timescale 1ns/1ps
module irc_isa_host (
  input wire logic pclk,
  input wire logic [19:0] sa,
  input wire logic [1:0] shm_upper,
  input wire logic [15:0] irq_out,
  input wire logic [15:0] irq_oe,
  input wire logic [7:0] drq_out,
  input wire logic [7:0] drq_oe,
  output logic ext_shared_match,
  output logic [15:0] irq_line,
  output logic [7:0] drq_line
);
  logic flip = 1'b0;
  // released lines flip each cycle so a stale level never passes for a driven one
  always @(posedge pclk) flip <= ~flip;
  assign ext_shared_match = (sa[17:16] == shm_upper);
  assign irq_line = (irq_out & irq_oe) | ({16{flip}} & ~irq_oe);
  assign drq_line = (drq_out & drq_oe) | ({8{flip}} & ~drq_oe);
endmodule : irc_isa_host

// file: test/tb_top.sv
/*
 holds: self-checking bench for the resource configuration block.
 assumes: apb slave answers in its own time, the master waits for pready; outputs follow isa inputs one cycle later.
*/
`timescale 1ns/1ps
`include "irc_consts.svh"
module tb_top;
  import irc_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, load_valid = 0;
  logic int_req = 0, dma_req = 0, pready, pslverr, io_select, boot_select, boot_wide;
  logic shared_select, shared_wide, ext_shared_match, err, r, bw, sw, eb, es;
  logic [9:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rdv;
  logic [3:0] load_io_code = 0, load_boot_code = 0, ic, bc, bs, ss;
  logic [2:0] load_dma_code = 0;
  logic [4:0] shc;
  logic [1:0] up = 0;
  logic [19:0] sa = 0, a;
  logic [15:0] irq_out, irq_oe, irq_line, im;
  logic [7:0] drq_out, drq_oe, drq_line, dm;
  irc_mode_t m;
  int fails = 0, checked = 0;
  always #10 pclk = ~pclk;
  irc_top irc_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .load_valid(load_valid), .load_io_code(load_io_code), .load_dma_code(load_dma_code),
    .load_boot_code(load_boot_code), .sa(sa), .ext_shared_match(ext_shared_match), .int_req(int_req),
    .dma_req(dma_req), .io_select(io_select), .boot_select(boot_select), .boot_wide(boot_wide),
    .shared_select(shared_select), .shared_wide(shared_wide), .irq_out(irq_out), .irq_oe(irq_oe),
    .drq_out(drq_out), .drq_oe(drq_oe));
  irc_isa_host irc_isa_host_i (.pclk(pclk), .sa(sa), .shm_upper(up), .irq_out(irq_out), .irq_oe(irq_oe),
    .drq_out(drq_out), .drq_oe(drq_oe), .ext_shared_match(ext_shared_match), .irq_line(irq_line),
    .drq_line(drq_line));
  ////////////////////////////////////////
  function automatic logic [3:0] ign_of(input logic [3:0] s);
    case (s)
      4'hf: return 4'h0;
      4'he: return 4'h1;
      4'hc: return 4'h3;
      4'h8: return 4'h7;
      default: return 4'hf;
    endcase
  endfunction : ign_of
  // size-aligned window hit; f marks an invalid size
  function automatic logic mhit(input logic [3:0] c, input logic [3:0] s, input logic [3:0] n);
    logic [3:0] g;
    g = ign_of(s);
    return (g != 4'hf) && ((c & g) == 4'h0) && ((n | g) == (c | g));
  endfunction : mhit
  function automatic logic [15:0] irq_mask(input logic [3:0] c);
    case (c)
      4'h3, 4'h4, 4'h5, 4'h9, 4'ha, 4'hb: return 16'h0001 << c;
      4'hd: return 16'h1000;
      4'he: return 16'h8000;
      default: return 16'h0000;
    endcase
  endfunction : irq_mask
  function automatic logic [7:0] dma_mask(input logic [2:0] c);
    return (c == 3'h3 || c >= 3'h5) ? (8'h01 << c) : 8'h00;
  endfunction : dma_mask
  function automatic logic [3:0] pick_size();
    case ($urandom % 5)
      0: return 4'hf;
      1: return 4'he;
      2: return 4'hc;
      3: return 4'h8;
      default: return 4'($urandom);
    endcase
  endfunction : pick_size
  ////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // no wait-state limit here: a slave that never answers is caught by the watchdog
  task automatic apb(input logic w, input logic [7:0] i, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= {i, 2'b00}; pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    apb(1'b1, i, d);
  endtask : wr
  task automatic rd(input logic [7:0] i, input logic [31:0] e);
    apb(1'b0, i, 8'h00);
    chk("prdata", rdv, e);
  endtask : rd
  task automatic wcode(input logic [7:0] hi, input logic [3:0] c);
    wr(hi, {7'h0, c[3]});
    wr(hi + 8'h01, {c[2:0], 5'h0});
  endtask : wcode
  task automatic isa(input logic [19:0] x);
    @(posedge pclk);
    sa <= x;
    @(posedge pclk);
    #1;
  endtask : isa
  task complete_run();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run
  // the tests need about 2,500 cycles; four times that is ample
  initial begin
    #200000;
    fails++;
    complete_run();
  end
  ////////////////////////////////////////
  initial begin
    void'($urandom(32'hf1a41cbe));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(`IRC_IDX_IRQ_SEL, 32'h3);
    rd(`IRC_IDX_IRQ_TYPE, 32'h2);
    rd(`IRC_IDX_DMA_SEL, 32'h4);
    rd(`IRC_IDX_IO_BASE_HI, 32'h2);
    rd(`IRC_IDX_BOOT_BASE_HI, 32'hc);
    rd(`IRC_IDX_BOOT_SIZE_HI, 32'hfe);
    rd(`IRC_IDX_ACTIVATE, 32'h0);
    apb(1'b0, 8'h55, 8'h00);
    chk("pslverr", {31'h0, err}, 32'h1);
    $display("test reset_values done");
    ic = 4'($urandom);
    bc = 4'($urandom);
    @(posedge pclk);
    load_valid <= 1'b1; load_io_code <= ic; load_dma_code <= 3'h5; load_boot_code <= bc;
    @(posedge pclk);
    load_valid <= 1'b0;
    rd(`IRC_IDX_IO_BASE_HI, {30'h0, 1'b1, ic[3]});
    rd(`IRC_IDX_IO_BASE_LO, {24'h0, ic[2:0], 5'h0});
    rd(`IRC_IDX_DMA_SEL, 32'h5);
    rd(`IRC_IDX_BOOT_BASE_LO, {24'h0, bc[2:0], 5'h0});
    @(posedge pclk);
    int_req <= 1'b1; dma_req <= 1'b1;
    isa({10'h0, 1'b1, ic, 5'h0});
    chk("io_select", io_select, 1'b0);
    chk("irq_oe", irq_oe, 16'h0);
    chk("drq_oe", drq_oe, 8'h0);
    wr(`IRC_IDX_ACTIVATE, 8'h01);
    for (int i = 0; i < 24; i++) begin
      a = 20'($urandom);
      if (i[0]) a[8:5] = ic;
      isa(a);
      chk("io_select", io_select, a[9] && a[8:5] == ic);
      ic = 4'($urandom);
      wcode(`IRC_IDX_IO_BASE_HI, ic);
    end
    $display("test io_decode done");
    for (int t = 0; t < 2; t++) begin
      wr(`IRC_IDX_IRQ_TYPE, 8'(t));
      rd(`IRC_IDX_IRQ_TYPE, {30'h0, ~t[0], t[0]});
      wr(`IRC_IDX_ARCH_MODE, t[0] ? 8'h02 : 8'h01);
      for (int c = 0; c < 16; c++) begin
        wr(`IRC_IDX_IRQ_SEL, 8'(c));
        wr(`IRC_IDX_DMA_SEL, 8'(c % 8));
        r = 1'($urandom);
        @(posedge pclk);
        int_req <= r; dma_req <= r;
        isa(20'h0);
        im = irq_mask(4'(c));
        dm = t[0] ? 8'h0 : dma_mask(3'(c));
        chk("irq_oe", irq_oe, im);
        chk("irq_line", irq_line & im, im & {16{t[0] ^ r}});
        chk("drq_oe", drq_oe, dm);
        chk("drq_line", drq_line & dm, dm & {8{r}});
      end
    end
    $display("test irq_dma done");
    for (int i = 0; i < 40; i++) begin
      m = irc_mode_t'(3'b001 << ($urandom % 3));
      bc = 4'($urandom); bs = pick_size(); ss = pick_size();
      shc = 5'($urandom); bw = 1'($urandom); sw = 1'($urandom);
      @(posedge pclk);
      up <= shc[4:3];
      wr(`IRC_IDX_ARCH_MODE, {5'h0, m});
      wcode(`IRC_IDX_BOOT_BASE_HI, bc);
      wcode(`IRC_IDX_BOOT_SIZE_HI, bs);
      wcode(`IRC_IDX_SHM_SIZE_HI, ss);
      wr(`IRC_IDX_SHM_BASE_HI, {6'h0, shc[4:3]});
      wr(`IRC_IDX_SHM_BASE_LO, {shc[2:0], 5'h0});
      wr(`IRC_IDX_BOOT_WIDTH, {6'h0, bw, 1'b0});
      wr(`IRC_IDX_SHM_WIDTH, {6'h0, sw, 1'b0});
      for (int k = 0; k < 6; k++) begin
        a = 20'($urandom);
        if (k < 4) a[19:17] = 3'b110;
        if (k[0]) a[16:13] = bc;
        else a[15:13] = shc[2:0];
        isa(a);
        eb = a[19:17] == 3'b110 && mhit(bc, bs, a[16:13]);
        es = m == IRC_SHARED_MEM && a[17:16] == shc[4:3] && mhit({1'b0, shc[2:0]}, ss, {1'b0, a[15:13]});
        chk("boot_select", boot_select, eb);
        chk("boot_wide", boot_wide, eb && bw && m != IRC_BUS_MASTER);
        chk("shared_select", shared_select, es);
        chk("shared_wide", shared_wide, es && sw);
      end
    end
    $display("test memory_decode done");
    complete_run();
  end
endmodule : tb_top
